/* rtl/rptauth_pkg.sv */
// Package: register map and field positions for repeater auth sequencing
package rptauth_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] KEY_OFF = 8'h08;
   localparam logic [7:0] INFO_OFF = 8'h0C;
   localparam logic [7:0] HASH_OFF = 8'h10;
   localparam logic [7:0] AKEY_OFF = 8'h14;
   localparam logic [7:0] SECRET_OFF = 8'h18;
   localparam logic [7:0] CLEAR_OFF = 8'h1C;
   // Control field positions
   localparam int CTRL_CRYPT_BIT = 0;
   localparam int CTRL_FWD_BIT = 1;
   localparam int CTRL_REV_BIT = 2;
   localparam int CTRL_PIN0_BIT = 3;
   localparam int CTRL_PIN1_BIT = 4;
   localparam int CTRL_READY_BIT = 5;
   localparam int CTRL_NEWDEV_BIT = 6;
   localparam int CTRL_LIST_CLR_BIT = 7;
   localparam int CTRL_W = 7;
   // Status field positions
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_BEGUN_BIT = 1;
   localparam int STAT_BLOCKED_BIT = 2;
   localparam int STAT_BUSY_BIT = 3;
   localparam int STAT_TOOMANY_BIT = 4;
   localparam int STAT_TOODEEP_BIT = 5;
   // Device-information field positions
   localparam int INFO_TOOMANY_BIT = 7;
   localparam int INFO_TOODEEP_BIT = 11;
   // Control reset value and hash constants
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h06;
   localparam logic [31:0] HASH_SEED = 32'h6A09E667;
   localparam logic [31:0] HASH_MULT = 32'h9E3779B1;
endpackage

/* rtl/list_hasher.sv */
// Sequential hash over key list, information word and secret value
`timescale 1ns/100ps
`default_nettype none
module list_hasher
   import rptauth_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Start and operands
   input wire logic start,
   input wire logic [AW:0] count,
   input wire logic [31:0] info,
   input wire logic [31:0] secret,
   // List read port
   output logic [AW-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   // Result
   output logic busy,
   output logic [31:0] hash
);
   if ((1 << AW) < DEPTH) begin : g_bad_size
      $error("AW too narrow for DEPTH");
   end
   logic [AW:0] idx_q, idx_d;
   logic busy_q, busy_d;
   logic [31:0] acc_q, acc_d;
   wire logic in_list = idx_q < count;
   wire logic [31:0] word = in_list ? rd_data : (idx_q == count ? info : secret);
   wire logic [31:0] mixed = ({acc_q[26:0], acc_q[31:27]} ^ word) * HASH_MULT;
   wire logic last = idx_q == count + (AW+1)'(1);
   assign rd_addr = idx_q[AW-1:0];
   assign busy = busy_q;
   assign hash = acc_q;
   always_comb begin
      idx_d = idx_q;
      busy_d = busy_q;
      acc_d = acc_q;
      if (start) begin
         idx_d = '0;
         busy_d = 1'b1;
         acc_d = HASH_SEED;
      end else if (busy_q) begin
         acc_d = mixed;
         idx_d = idx_q + (AW+1)'(1);
         if (last) busy_d = 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= '0;
         busy_q <= 1'b0;
         acc_q <= '0;
      end else begin
         idx_q <= idx_d;
         busy_q <= busy_d;
         acc_q <= acc_d;
      end
   end
endmodule
`default_nettype wire

/* rtl/repeater_auth_sequencing.sv */
// Repeater-side authentication sequencing with APB register access
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module repeater_auth_sequencing
   import rptauth_pkg::*;
#(
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // APB response
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Video timing pin
   input wire logic vsync,
   // Datapath and control channel
   output logic crypt_active,
   output logic ctrl_chan_blocked,
   // General-purpose pins
   output logic general_pin_zero,
   output logic general_pin_one
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || DEPTH > 256) begin : g_bad_depth
      $error("DEPTH out of range");
   end

   typedef enum logic [1:0] {
      CR_OFF = 2'b01,
      CR_ON = 2'b10
   } crypt_e;

   // Registers
   logic [CTRL_W-1:0] ctrl_q;
   logic [31:0] info_q, secret_q;
   logic [AW:0] count_q;
   logic begun_q;
   crypt_e crypt_q, crypt_d;
   logic vs_s1_q, vs_s2_q, vs_s3_q;
   logic [31:0] list_mem [DEPTH];
   logic hash_busy;
   logic [31:0] hash_val;
   logic [AW-1:0] rd_addr;

   // Bus decode
   wire logic wr = psel & penable & pwrite;
   // Read word fetched in setup cycle, stands in access cycle
   wire logic rd_setup = psel & ~penable & ~pwrite;
   wire logic hit_ctrl = paddr == CTRL_OFF;
   wire logic hit_status = paddr == STATUS_OFF;
   wire logic hit_key = paddr == KEY_OFF;
   wire logic hit_info = paddr == INFO_OFF;
   wire logic hit_hash = paddr == HASH_OFF;
   wire logic hit_akey = paddr == AKEY_OFF;
   wire logic hit_secret = paddr == SECRET_OFF;
   wire logic hit_clear = paddr == CLEAR_OFF;
   wire logic mapped = hit_ctrl | hit_status | hit_key | hit_info | hit_hash | hit_akey
      | hit_secret | hit_clear;
   wire logic list_full = count_q == (AW+1)'(DEPTH);
   wire logic key_wr = wr & hit_key & ~list_full;
   wire logic info_wr = wr & hit_info;
   wire logic list_clr = wr & hit_ctrl & pwdata[CTRL_LIST_CLR_BIT];
   wire logic [AW-1:0] wr_slot = count_q[AW-1:0];
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Control fields
   wire logic crypt_enable = ctrl_q[CTRL_CRYPT_BIT];
   wire logic pin0_crypt_select = ctrl_q[CTRL_PIN0_BIT];
   wire logic pin1_auth_select = ctrl_q[CTRL_PIN1_BIT];
   wire logic forward_ctrl_chan_on = pwdata[CTRL_FWD_BIT];
   wire logic reverse_ctrl_chan_on = pwdata[CTRL_REV_BIT];
   wire logic block_req = wr & hit_ctrl & ~forward_ctrl_chan_on & ~reverse_ctrl_chan_on;
   wire logic unblock_req = wr & hit_ctrl & forward_ctrl_chan_on & reverse_ctrl_chan_on;
   wire logic begun_set = wr & hit_akey;
   wire logic begun_clr = wr & hit_clear & pwdata[STAT_BEGUN_BIT];
   wire logic crypt_on = crypt_q == CR_ON;

   // Status word
   wire logic too_many = info_q[INFO_TOOMANY_BIT];
   wire logic too_deep = info_q[INFO_TOODEEP_BIT];
   wire logic [31:0] status_word = {26'h0, too_deep, too_many, hash_busy,
      ctrl_chan_blocked, begun_q, crypt_on};
   wire logic [31:0] count_word = 32'(count_q);
   wire logic [31:0] rd_mux = hit_ctrl ? {25'h0, ctrl_q} :
      hit_status ? status_word :
      hit_info ? info_q :
      hit_hash ? hash_val :
      hit_key ? count_word : 32'h0;

   // Control and stored words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_q <= CTRL_RST;
      else if (wr & hit_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) info_q <= '0;
      else if (info_wr) info_q <= pwdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) secret_q <= '0;
      else if (wr & hit_secret) secret_q <= pwdata;
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= '0;
      else if (rd_setup) prdata <= rd_mux;
   end

   // Key list storage
   always_ff @(posedge pclk) begin
      if (key_wr) list_mem[wr_slot] <= pwdata;
   end

   // Key count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) count_q <= '0;
      else if (list_clr) count_q <= '0;
      else if (key_wr) count_q <= count_q + (AW+1)'(1);
   end

   // Begun flag: set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begun_q <= 1'b0;
      else if (begun_set) begun_q <= 1'b1;
      else if (begun_clr) begun_q <= 1'b0;
   end

   // Vertical sync synchroniser and falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vs_s1_q <= 1'b0;
         vs_s2_q <= 1'b0;
         vs_s3_q <= 1'b0;
      end else begin
         vs_s1_q <= vsync;
         vs_s2_q <= vs_s1_q;
         vs_s3_q <= vs_s2_q;
      end
   end
   // Falling edge of synchronised vsync
   wire logic vs_fall = vs_s3_q & ~vs_s2_q;
   wire logic crypt_go = vs_fall & crypt_enable;
   wire logic crypt_stop = vs_fall & ~crypt_enable;

   // Crypt state follows enable bit only at sync falling edge
   always_comb begin
      crypt_d = crypt_q;
      case (crypt_q)
         CR_OFF: if (crypt_go) crypt_d = CR_ON;
         CR_ON: if (crypt_stop) crypt_d = CR_OFF;
         default: crypt_d = CR_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) crypt_q <= CR_OFF;
      else crypt_q <= crypt_d;
   end
   assign crypt_active = crypt_on;

   // Channel blocking needs both enables low; both high unblocks
   logic blocked_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) blocked_q <= 1'b0;
      else if (block_req) blocked_q <= 1'b1;
      else if (unblock_req) blocked_q <= 1'b0;
   end
   assign ctrl_chan_blocked = blocked_q;

   // Pin functions
   assign general_pin_zero = pin0_crypt_select & crypt_enable;
   assign general_pin_one = pin1_auth_select & begun_q;

   // Hash engine, started by info word write
   wire logic [31:0] list_word = list_mem[rd_addr];
   list_hasher #(.DEPTH(DEPTH), .AW(AW)) u_hash (
      .pclk(pclk),
      .presetn(presetn),
      .start(info_wr),
      .count(count_q),
      .info(info_q),
      .secret(secret_q),
      .rd_addr(rd_addr),
      .rd_data(list_word),
      .busy(hash_busy),
      .hash(hash_val)
   );
endmodule
`default_nettype wire

/* sim/vsync_source.sv */
// Video timing model giving one vsync low pulse per request
`timescale 1ns/100ps
`default_nettype none
module vsync_source #(
   parameter int LOW_CYC = 6
) (
   // Clock and request
   input wire logic pclk,
   input wire logic frame_go,
   // Sync pin
   output logic vsync
);
   int cnt = 0;
   always @(posedge pclk) begin
      cnt <= frame_go ? LOW_CYC : (cnt > 0 ? cnt - 1 : 0);
   end
   assign vsync = (cnt == 0);
endmodule
`default_nettype wire

/* sim/rptauth_props.sv */
// Port checker for repeater auth sequencing
`timescale 1ns/100ps
`default_nettype none
module rptauth_props
   import rptauth_pkg::*;
#(parameter int DEPTH = 16) (
   // APB
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // Pins
   input wire logic vsync, crypt_active, ctrl_chan_blocked, general_pin_zero, general_pin_one
);
   logic [CTRL_W-1:0] sh_q;
   wire logic wr = psel & penable & pwrite;
   wire logic wr_ctrl = wr & (paddr == CTRL_OFF);
   wire logic wr_akey = wr & (paddr == AKEY_OFF);
   wire logic wr_clr = wr & (paddr == CLEAR_OFF) & pwdata[1];
   wire logic both_off = wr_ctrl & (pwdata[2:1] == 2'h0);
   wire logic both_on = wr_ctrl & (pwdata[2:1] == 2'h3);
   wire logic bad_addr = (paddr > CLEAR_OFF) | (paddr[1:0] != 2'h0);
   wire logic pin0_exp = sh_q[CTRL_PIN0_BIT] & sh_q[CTRL_CRYPT_BIT];
   wire logic keep_one = !wr_clr && !(wr_ctrl && !pwdata[CTRL_PIN1_BIT]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= CTRL_RST;
      end else if (wr_ctrl) begin
         sh_q <= pwdata[CTRL_W-1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pin_zero_mirror: assert property (general_pin_zero == pin0_exp)
      else $error("pin zero wrong");
   a_crypt_follow: assert property ($fell(vsync) && sh_q[0] != crypt_active
      |-> ##[1:7] crypt_active == sh_q[0]) else $error("crypt missed sync");
   a_crypt_at_sync: assert property ($changed(crypt_active) |-> !$past(vsync))
      else $error("crypt moved off sync");
   a_block_set: assert property (both_off |=> ctrl_chan_blocked)
      else $error("not blocked");
   a_block_clear: assert property (both_on |=> !ctrl_chan_blocked)
      else $error("not unblocked");
   a_block_hold: assert property ($changed(ctrl_chan_blocked) |-> $past(wr_ctrl))
      else $error("block moved alone");
   a_pin_one_set: assert property (wr_akey && sh_q[CTRL_PIN1_BIT] |=> general_pin_one)
      else $error("pin one not set");
   a_pin_one_hold: assert property (general_pin_one && keep_one |=> general_pin_one)
      else $error("pin one dropped");
   a_bad_addr_err: assert property (psel && penable && bad_addr |-> pslverr)
      else $error("no slave error");
   c_crypt_on: cover property ($rose(crypt_active));
   c_blocked: cover property ($rose(ctrl_chan_blocked));
   c_pin_one: cover property ($rose(general_pin_one));
endmodule
bind repeater_auth_sequencing rptauth_props #(.DEPTH(DEPTH)) u_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .vsync(vsync),
   .crypt_active(crypt_active), .ctrl_chan_blocked(ctrl_chan_blocked),
   .general_pin_zero(general_pin_zero), .general_pin_one(general_pin_one));
`default_nettype wire

/* sim/test_repeater_auth_sequencing.sv */
// Testbench for repeater auth sequencing
`timescale 1ns/100ps
`default_nettype none
module test_repeater_auth_sequencing
   import rptauth_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic frame_go = 1'b0, pready, pslverr, vsync, crypt_active, ctrl_chan_blocked;
   logic general_pin_zero, general_pin_one, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, h1;
   logic [31:0] blk_d[4] = '{32'h08, 32'h0A, 32'h0C, 32'h0E};
   logic [31:0] blk_e[4] = '{32'h1, 32'h1, 32'h1, 32'h0};
   int mismatches = 0, checks_done = 0;
   always #50 pclk = ~pclk;
   repeater_auth_sequencing #(.DEPTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vsync(vsync), .crypt_active(crypt_active),
      .ctrl_chan_blocked(ctrl_chan_blocked), .general_pin_zero(general_pin_zero),
      .general_pin_one(general_pin_one));
   vsync_source sync (.pclk(pclk), .frame_go(frame_go), .vsync(vsync));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      rd = prdata;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic wait_hash;
      xfer(1'b0, STATUS_OFF, 32'h0);
      chk(32'(rd[STAT_BUSY_BIT]), 32'h1);
      for (int i = 0; i < 40 && rd[STAT_BUSY_BIT] !== 1'b0; i++) xfer(1'b0, STATUS_OFF, 32'h0);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      print_verdict;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(CTRL_OFF, 32'h6);
      rd_chk(STATUS_OFF, 32'h0);
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, CTRL_OFF, k ? 32'hE : 32'hF);
         idle(6);
         chk(32'(crypt_active), 32'(k));
         chk(32'(general_pin_zero), 32'(1 - k));
         @(posedge pclk) frame_go <= 1'b1;
         @(posedge pclk) frame_go <= 1'b0;
         idle(12);
         chk(32'(crypt_active), 32'(1 - k));
      end
      foreach (blk_d[i]) begin
         xfer(1'b1, CTRL_OFF, blk_d[i]);
         chk(32'(ctrl_chan_blocked), blk_e[i]);
      end
      xfer(1'b1, CTRL_OFF, 32'h1E);
      chk(32'(general_pin_one), 32'h0);
      xfer(1'b1, AKEY_OFF, 32'h5A);
      chk(32'(general_pin_one), 32'h1);
      idle(20);
      rd_chk(STATUS_OFF, 32'h2);
      xfer(1'b1, CLEAR_OFF, 32'h2);
      chk(32'(general_pin_one), 32'h0);
      xfer(1'b1, AKEY_OFF, 32'h5B);
      chk(32'(general_pin_one), 32'h1);
      xfer(1'b1, KEY_OFF, 32'hA1);
      xfer(1'b1, KEY_OFF, 32'hB2);
      rd_chk(KEY_OFF, 32'h2);
      xfer(1'b1, INFO_OFF, 32'h80);
      wait_hash;
      rd_chk(STATUS_OFF, 32'h12);
      xfer(1'b0, HASH_OFF, 32'h0);
      h1 = rd;
      xfer(1'b1, INFO_OFF, 32'h800);
      wait_hash;
      rd_chk(STATUS_OFF, 32'h22);
      xfer(1'b0, HASH_OFF, 32'h0);
      chk(32'(h1 !== rd), 32'h1);
      xfer(1'b1, CTRL_OFF, 32'hFE);
      rd_chk(CTRL_OFF, 32'h7E);
      rd_chk(KEY_OFF, 32'h0);
      xfer(1'b0, 8'h20, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      print_verdict;
   end
endmodule
`default_nettype wire
